/* hdl/trs_mr_debounce.sv */
// debounce filter for the manual reset pin
`timescale 1ns/1ps
module trs_mr_debounce
  import trs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic raw,
  output logic      level,
  output logic      accept
);

  logic                meta_ff;   // first sync stage
  logic                sync_ff;   // second sync stage
  logic                level_ff;  // filtered level
  logic                accept_ff; // one cycle when a high level is accepted
  logic [MR_CNT_W-1:0] cnt_ff;    // cycles the new level held

  assign level  = level_ff;
  assign accept = accept_ff;

  // two stage synchroniser, the pin is asynchronous
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
    end
  end

  // a change must hold for the full window, else it is a glitch
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff    <= '0;
      level_ff  <= 1'b0;
      accept_ff <= 1'b0;
    end else begin
      accept_ff <= 1'b0;
      if (sync_ff == level_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff == MR_CNT_W'(MR_CYCLES - 1)) begin
        cnt_ff    <= '0;
        level_ff  <= sync_ff;
        accept_ff <= sync_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule

/* hdl/trs_pkg.sv */
// constants and types of the triple rail sequencer
package trs_pkg;

  // ************************************************************
  // clock, prescaler and debounce timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;       // 100 MHz system clock
  localparam int TICK_PERIOD_NS  = 1000000;  // prescaler tick, 1 ms
  localparam int TICK_PERIOD_MS  = 1;        // same tick in ms
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRE_W           = 17;       // prescaler counter width
  localparam int MR_MIN_NS       = 5000;     // manual reset least width
  localparam int MR_CYCLES       = (MR_MIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int MR_CNT_W        = 10;       // debounce counter width

  // ************************************************************
  // delay selections, in ms, and their tick counts
  // ************************************************************
  localparam int DLY_SEL0_MS = 100;          // default selection
  localparam int DLY_SEL1_MS = 500;
  localparam int DLY_SEL2_MS = 1000;
  localparam int DLY_SEL3_MS = 5000;
  localparam int DLY_W       = 13;           // holds 5000 ticks

  // tick count for a two bit delay selection
  function automatic logic [DLY_W-1:0] trs_dly_ticks(
    input logic [1:0] sel);
    logic [DLY_W-1:0] t;
    case (sel)
      2'h0:    t = DLY_W'(DLY_SEL0_MS / TICK_PERIOD_MS);
      2'h1:    t = DLY_W'(DLY_SEL1_MS / TICK_PERIOD_MS);
      2'h2:    t = DLY_W'(DLY_SEL2_MS / TICK_PERIOD_MS);
      default: t = DLY_W'(DLY_SEL3_MS / TICK_PERIOD_MS);
    endcase
    return t;
  endfunction

  // ************************************************************
  // pins, register map and field layout
  // ************************************************************
  localparam int NUM_RAILS = 3;              // rails 1, 3, 4
  localparam int NUM_PINS  = 7;              // synchronised pins
  localparam int PIN_WP    = 3;
  localparam int PIN_SEL0  = 4;
  localparam int PIN_SEL1  = 5;
  localparam int PIN_SDA   = 6;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TARGET   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_FAULT    = 8'h0C;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;

  localparam int CTRL_W        = 10;
  localparam int CTRL_RSEL_LSB = 0;          // two bits per rail
  localparam int CTRL_POR_LSB  = 6;
  localparam int CTRL_WPA_BIT  = 8;
  localparam int CTRL_SDA_BIT  = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int FAULT_W       = 4;          // rails then manual reset
  localparam int INT_W         = 3;
  localparam int INT_RAIL_FAIL = 0;
  localparam int INT_MR        = 1;
  localparam int INT_RST_REL   = 2;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_POR_WAIT,
    SEQ_RUN
  } trs_seq_t;

endpackage

/* hdl/trs_rail_delay.sv */
// delay timer for one monitored rail
`timescale 1ns/1ps
module trs_rail_delay
  import trs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  trs_rail_if.timer rif
);

  logic [DLY_W-1:0] cnt_ff;   // elapsed ticks
  logic             done_ff;  // delay reached
  logic [DLY_W-1:0] target;   // ticks for the selection

  assign target   = trs_dly_ticks(rif.sel);
  assign rif.done = done_ff;

  // counts ticks while the rail is good
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (rif.restart || !rif.sense_good) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (rif.tick && !done_ff) begin
      if (cnt_ff == target - 1'b1) begin
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule

/* hdl/trs_rail_if.sv */
// interface between the sequencer and one rail delay timer
`timescale 1ns/1ps
interface trs_rail_if;
  logic       tick;        // prescaler tick pulse
  logic       restart;     // forces the timer back to zero
  logic       sense_good;  // synchronised comparator result
  logic [1:0] sel;         // delay selection
  logic       done;        // delay expired, rail counts as good

  modport timer (input tick, input restart, input sense_good,
                 input sel, output done);
  modport ctl   (output tick, output restart, output sense_good,
                 output sel, input done);
endinterface

/* hdl/trs_sequencer.sv */
// top of the triple rail sequencer
// What this block does
// - rail output released when low, pulled when good
// - each rail applies its own selected delay
// - reset held until all rails good, sequenced
// - extra programmable delay before reset release
// - protect pin plus arm bit rejects writes
// - manual reset high starts reset sequence
// - manual reset is debounced against glitches
// - manual reset asserts reset, restarts rail outputs
// - any rail drop resets and resequences all
// - select pins compared with target address
// - data line open drain, always sampled
// - rail delay codes 100ms 500ms 1s 5s
// - reset release codes 100ms 500ms 1s 5s
// - fault log zero at reset, cleared on failure
// - after release, each output waits own delay
`timescale 1ns/1ps
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF  // clocks per 1 ms tick
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        rail1_sense,
  input  wire logic        rail3_sense,
  input  wire logic        rail4_sense,
  input  wire logic        manual_reset_in,
  input  wire logic        wp_in,
  input  wire logic        dev_sel0,
  input  wire logic        dev_sel1,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             rail1_good_delayed_n_out,
  output logic             rail1_good_delayed_n_oe,
  output logic             rail3_good_delayed_n_out,
  output logic             rail3_good_delayed_n_oe,
  output logic             rail4_good_delayed_n_out,
  output logic             rail4_good_delayed_n_oe,
  output logic             sys_reset_n_out,
  output logic             sys_reset_n_oe,
  output logic             irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [NUM_PINS-1:0]  pin_raw;       // asynchronous pins
  logic [NUM_PINS-1:0]  pin_meta_ff;   // first stage only
  logic [NUM_PINS-1:0]  pin_sync_ff;   // safe to use
  logic [NUM_RAILS-1:0] sense_good;    // synchronised rail senses
  logic [NUM_RAILS-1:0] sense_prev_ff; // for falling edge
  logic [NUM_RAILS-1:0] rail_fail;     // rail just dropped
  logic                 any_fail;      // some rail dropped

  assign pin_raw = {sda_in, dev_sel1, dev_sel0, wp_in,
                    rail4_sense, rail3_sense, rail1_sense};

  // two flop pin synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign sense_good = pin_sync_ff[NUM_RAILS-1:0];

  // last sense level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sense_prev_ff <= '0;
    end else begin
      sense_prev_ff <= sense_good;
    end
  end

  assign rail_fail = sense_prev_ff & ~sense_good;
  assign any_fail  = |rail_fail;

  // ************************************************************
  // prescaler
  // ************************************************************
  logic [PRE_W-1:0] pre_cnt_ff;  // free running divider
  logic             tick_ff;     // one cycle every tick period

  // free running, so a delay may start up to one tick early
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_cnt_ff <= '0;
      tick_ff    <= 1'b0;
    end else if (pre_cnt_ff == PRE_W'(TICK_CYCLES - 1)) begin
      pre_cnt_ff <= '0;
      tick_ff    <= 1'b1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 1'b1;
      tick_ff    <= 1'b0;
    end
  end

  // ************************************************************
  // manual reset and rail timers
  // ************************************************************
  logic                 mr_level;   // debounced manual reset
  logic                 mr_accept;  // one cycle when a press is accepted
  logic                 restart;    // resequence every rail
  logic [NUM_RAILS-1:0] rail_done;  // rail delay expired
  logic [CTRL_W-1:0]    ctrl_ff;    // control register

  // short pulses never reach mr_level
  trs_mr_debounce u_mr (
    .clk    (clk),
    .rstn   (rstn),
    .raw    (manual_reset_in),
    .level  (mr_level),
    .accept (mr_accept)
  );

  // manual reset or rail drop restarts all
  assign restart = mr_level | any_fail;

  trs_rail_if rif [NUM_RAILS] ();

  // one timer per rail
  generate
    for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
      assign rif[i].tick       = tick_ff;
      assign rif[i].restart    = restart;
      assign rif[i].sense_good = sense_good[i];
      assign rif[i].sel        = ctrl_ff[CTRL_RSEL_LSB+2*i +: 2];
      assign rail_done[i]      = rif[i].done;
      trs_rail_delay u_rail (
        .clk  (clk),
        .rstn (rstn),
        .rif  (rif[i])
      );
    end
  endgenerate

  // ************************************************************
  // system reset sequencer
  // ************************************************************
  trs_seq_t         seq_ff;      // sequencer state
  logic [DLY_W-1:0] por_cnt_ff;  // ticks spent in release wait
  logic [DLY_W-1:0] por_target;  // ticks for the selection
  logic             all_done;    // all rails good, no manual reset
  logic             por_expire;  // release delay reached

  assign all_done   = (&rail_done) & ~mr_level;
  assign por_target = trs_dly_ticks(ctrl_ff[CTRL_POR_LSB +: 2]);
  assign por_expire = tick_ff && (por_cnt_ff == por_target - 1'b1);

  // hold, then wait the release delay, then run
  always_ff @(posedge clk) begin
    if (!rstn) begin
      seq_ff <= SEQ_HOLD;
    end else begin
      case (seq_ff)
        SEQ_HOLD: begin
          if (all_done && !restart) begin
            seq_ff <= SEQ_POR_WAIT;
          end
        end
        SEQ_POR_WAIT: begin
          if (!all_done || restart) begin
            seq_ff <= SEQ_HOLD;
          end else if (por_expire) begin
            seq_ff <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (!all_done || restart) begin
            seq_ff <= SEQ_HOLD;
          end
        end
        default: seq_ff <= SEQ_HOLD;
      endcase
    end
  end

  // release delay counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      por_cnt_ff <= '0;
    end else if (seq_ff != SEQ_POR_WAIT) begin
      por_cnt_ff <= '0;
    end else if (tick_ff) begin
      por_cnt_ff <= por_cnt_ff + 1'b1;
    end
  end

  // ************************************************************
  // open drain outputs
  // ************************************************************
  logic [NUM_RAILS-1:0] rail_oe_ff;  // pulls rail output low
  logic                 rst_oe_ff;   // pulls system reset low
  logic                 od_low_ff;   // driven level, always low
  logic                 sda_oe_ff;   // pulls data line low
  logic [1:0]           target_ff;   // target select bits
  logic                 dev_match_ff;

  // outputs only ever pull low; the pull-up makes the high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rail_oe_ff <= '0;
      rst_oe_ff  <= 1'b1;
      od_low_ff  <= 1'b0;
    end else begin
      rail_oe_ff <= rail_done & ~{NUM_RAILS{restart}};
      rst_oe_ff  <= (seq_ff != SEQ_RUN) | restart;
      od_low_ff  <= 1'b0;
    end
  end

  // select match and data line drive
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dev_match_ff <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else begin
      dev_match_ff <= target_ff == {pin_sync_ff[PIN_SEL1],
                                    pin_sync_ff[PIN_SEL0]};
      sda_oe_ff    <= ctrl_ff[CTRL_SDA_BIT] & dev_match_ff;
    end
  end

  assign rail1_good_delayed_n_out = od_low_ff;
  assign rail3_good_delayed_n_out = od_low_ff;
  assign rail4_good_delayed_n_out = od_low_ff;
  assign rail1_good_delayed_n_oe  = rail_oe_ff[0];
  assign rail3_good_delayed_n_oe  = rail_oe_ff[1];
  assign rail4_good_delayed_n_oe  = rail_oe_ff[2];
  assign sys_reset_n_out          = od_low_ff;
  assign sys_reset_n_oe           = rst_oe_ff;
  assign sda_out                  = od_low_ff;
  assign sda_oe                   = sda_oe_ff;

  // ************************************************************
  // apb slave
  // ************************************************************
  logic        pready_ff;   // answer in first access cycle
  logic        pslverr_ff;  // unmapped or protected
  logic [31:0] prdata_ff;   // read data taken at setup
  logic        setup;       // setup phase of a transfer
  logic        access_done; // transfer completes this edge
  logic        wr_prot;     // writes locked
  logic        wr_ok;       // accepted write completes
  logic        addr_hit;    // address is mapped
  logic [31:0] rd_val;      // read mux
  logic [31:0] status_word; // live status

  assign setup       = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr_prot     = pin_sync_ff[PIN_WP] & ctrl_ff[CTRL_WPA_BIT];
  assign wr_ok       = access_done & pwrite & ~pslverr_ff;

  assign status_word = {21'h000000, pin_sync_ff[PIN_WP],
                        pin_sync_ff[PIN_SDA], dev_match_ff, mr_level,
                        rst_oe_ff, rail_done, sense_good};

  logic [INT_W-1:0]   int_stat_ff;  // sticky event bits
  logic [INT_W-1:0]   int_mask_ff;  // enable per event
  logic [FAULT_W-1:0] fault_ff;     // fault log

  // read mux
  always_comb begin
    rd_val   = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      REG_CTRL:     rd_val = 32'(ctrl_ff);
      REG_TARGET:   rd_val = 32'(target_ff);
      REG_STATUS:   rd_val = status_word;
      REG_FAULT:    rd_val = 32'(fault_ff);
      REG_INT_STAT: rd_val = 32'(int_stat_ff);
      REG_INT_MASK: rd_val = 32'(int_mask_ff);
      default:      addr_hit = 1'b0;
    endcase
  end

  // zero wait states
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (setup) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~addr_hit | (pwrite & wr_prot);
      prdata_ff  <= pwrite ? 32'h00000000 : rd_val;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  // ************************************************************
  // registers
  // ************************************************************
  logic [INT_W-1:0]   int_event;  // events this cycle
  logic [INT_W-1:0]   rd_clr;     // bits handed to software
  logic [FAULT_W-1:0] fault_src;  // failing sources
  logic               irq_ff;

  assign int_event = {seq_ff == SEQ_POR_WAIT && all_done && !restart
                      && por_expire, mr_accept, any_fail};
  assign fault_src = {mr_accept, rail_fail};
  // only bits that were returned get cleared, nothing is lost
  assign rd_clr    = (access_done && !pwrite && paddr == REG_INT_STAT)
                     ? prdata_ff[INT_W-1:0] : '0;

  // control and target registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_ff   <= CTRL_RST;
      target_ff <= 2'h0;
    end else if (wr_ok && paddr == REG_CTRL) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end else if (wr_ok && paddr == REG_TARGET) begin
      target_ff <= pwdata[1:0];
    end
  end

  // fault log, a failure wins over a write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_ff <= '0;
    end else if (wr_ok && paddr == REG_FAULT) begin
      fault_ff <= pwdata[FAULT_W-1:0] & ~fault_src;
    end else begin
      fault_ff <= fault_ff & ~fault_src;
    end
  end

  // sticky events, a new event beats the read clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_stat_ff <= '0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~rd_clr) | int_event;
    end
  end

  // mask register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_mask_ff <= '0;
    end else if (wr_ok && paddr == REG_INT_MASK) begin
      int_mask_ff <= pwdata[INT_W-1:0];
    end
  end

  // level interrupt
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

  assign irq = irq_ff;

endmodule

/* verif/trs_board_model.sv */
// model of the supplies and the reset button on the board
`timescale 1ns/1ps
module trs_board_model (
  input  wire logic       clk,
  input  wire logic [2:0] supply_on,
  output logic      [2:0] sense,
  output logic            mr
);
  initial sense = 3'h0;
  initial mr = 1'b0;
  // one cycle settle
  always @(posedge clk) begin
    sense <= supply_on;
  end
  // press held c cycles
  task automatic press(input int c);
    mr <= 1'b1;
    repeat (c) @(posedge clk);
    mr <= 1'b0;
  endtask
endmodule

/* verif/trs_sequencer_props.sv */
// port level checker of the triple rail sequencer
`timescale 1ns/1ps
module trs_sequencer_props
  import trs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        rail1_sense,
  input wire logic        rail3_sense,
  input wire logic        rail4_sense,
  input wire logic        manual_reset_in,
  input wire logic        wp_in,
  input wire logic        sda_out,
  input wire logic        sys_reset_n_out,
  input wire logic        rail1_good_delayed_n_oe,
  input wire logic        rail3_good_delayed_n_oe,
  input wire logic        rail4_good_delayed_n_oe,
  input wire logic        sys_reset_n_oe,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ************************************************************
  // helper logic
  // ************************************************************
  // shortest code less one tick
  localparam logic [15:0] MINC = 16'((DLY_SEL0_MS - 1) * TICK_CYCLES);
  logic [15:0] hi1_ff;  // rail1 sense high run
  logic [15:0] ad_ff;   // all rails done run
  logic [15:0] mr_ff;   // manual reset high run
  logic        wpa_ff;  // shadow of the protect arm bit
  logic        allhi;   // all senses high
  assign allhi = rail1_sense & rail3_sense & rail4_sense;
  // saturating run counter
  function automatic logic [15:0] nx(logic [15:0] c, logic on);
    return !on ? 16'h0000 : (&c ? c : c + 16'h0001);
  endfunction
  // run counters
  always_ff @(posedge clk) begin
    hi1_ff <= !rstn ? 16'h0000 : nx(hi1_ff, rail1_sense);
    ad_ff  <= !rstn ? 16'h0000 : nx(ad_ff, rail1_good_delayed_n_oe
              & rail3_good_delayed_n_oe & rail4_good_delayed_n_oe);
    mr_ff  <= !rstn ? 16'h0000 : nx(mr_ff, manual_reset_in);
  end
  // arm bit shadow
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wpa_ff <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr
                 && paddr == REG_CTRL) begin
      wpa_ff <= pwdata[CTRL_WPA_BIT];
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_locked;
    s_setup ##0 pwrite && wpa_ff && wp_in && $past(wp_in, 3);
  endsequence
  AST_RAIL_OFF: assert property ($fell(rail1_sense) |-> ##[1:6]
    !rail1_good_delayed_n_oe) else $error("rail1 stays good");
  AST_RST_REL: assert property ($fell(sys_reset_n_oe) |->
    ad_ff >= MINC) else $error("reset released early");
  AST_DROP_RST: assert property ($fell(rail4_good_delayed_n_oe)
    |-> ##[0:3] sys_reset_n_oe) else $error("no reset on drop");
  AST_RAIL_DLY: assert property ($rose(rail1_good_delayed_n_oe)
    |-> hi1_ff >= MINC) else $error("rail1 delay short");
  AST_MR_DEB: assert property ($fell(rail1_good_delayed_n_oe)
    && allhi && $past(allhi, 6) |-> $past(mr_ff, 4) >= 16'd490)
    else $error("glitch accepted");
  AST_MR_TAKE: assert property (mr_ff == 16'd520 |-> ##[0:4]
    (sys_reset_n_oe && !rail1_good_delayed_n_oe))
    else $error("manual reset ignored");
  AST_WP: assert property (s_wr_locked |=> pslverr)
    else $error("locked write accepted");
  AST_APB_RDY: assert property (s_setup |=> pready ##1 !pready)
    else $error("bad ready timing");
  AST_OPEN_DRAIN: assert property (!sda_out && !sys_reset_n_out)
    else $error("open drain driven high");
endmodule
bind trs_sequencer trs_sequencer_props #(.TICK_CYCLES(TICK_CYCLES))
  u_props (.clk, .rstn, .rail1_sense, .rail3_sense, .rail4_sense,
  .manual_reset_in, .wp_in, .sda_out, .sys_reset_n_out,
  .rail1_good_delayed_n_oe, .rail3_good_delayed_n_oe,
  .rail4_good_delayed_n_oe, .sys_reset_n_oe, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr);

/* verif/trs_sequencer_test.sv */
// self-checking bench of the triple rail sequencer
`timescale 1ns/1ps
module trs_sequencer_test;
  import trs_pkg::*;
  localparam int TC = 2;  // short tick
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wp_in = 1'b0, dev_sel0 = 1'b0, dev_sel1 = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] sup = 3'h0;
  logic [2:0] sense;
  logic mr, sda_out, sda_oe, irq, pready, pslverr, er;
  logic rail1_good_delayed_n_out, rail1_good_delayed_n_oe;
  logic rail3_good_delayed_n_out, rail3_good_delayed_n_oe;
  logic rail4_good_delayed_n_out, rail4_good_delayed_n_oe;
  logic sys_reset_n_out, sys_reset_n_oe;
  logic [31:0] prdata, rd;
  int n_errors = 0, n_checks = 0, cyc = 0, n;
  int ms[4] = '{DLY_SEL0_MS, DLY_SEL1_MS, DLY_SEL2_MS, DLY_SEL3_MS};
  always #5 clk = ~clk;
  trs_board_model bm (.clk, .supply_on(sup), .sense, .mr);
  // pulled-up data line
  trs_sequencer #(.TICK_CYCLES(TC)) uut (.clk, .rstn,
    .rail1_sense(sense[0]), .rail3_sense(sense[1]),
    .rail4_sense(sense[2]), .manual_reset_in(mr), .wp_in, .dev_sel0,
    .dev_sel1, .sda_in(!sda_oe), .sda_out, .sda_oe,
    .rail1_good_delayed_n_out, .rail1_good_delayed_n_oe,
    .rail3_good_delayed_n_out, .rail3_good_delayed_n_oe,
    .rail4_good_delayed_n_out, .rail4_good_delayed_n_oe,
    .sys_reset_n_out, .sys_reset_n_oe, .irq, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer after an idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, logic e);
    apb(1'b1, a, d);
    chk(er, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, logic e);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {e, x});
  endtask
  // cycles until rail1 good (k=0) or reset released (k=1)
  task automatic wt(input int k, output int c);
    c = 0;
    while ((k ? !sys_reset_n_oe : rail1_good_delayed_n_oe) !== 1'b1) begin
      @(posedge clk);
      c++;
    end
  endtask
  // wait must fall within the tick window of the code
  task automatic lim(input int c, input int m);
    chk(c >= (m / TICK_PERIOD_MS - 1) * TC && c <= m * TC + 8, 1);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({sys_reset_n_oe, rail1_good_delayed_n_oe}, 2'b10);
    rdc(REG_CTRL, 32'h0, 1'b0);
    rdc(REG_FAULT, 32'h0, 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    wr(REG_CTRL, 32'h100, 1'b0);
    wp_in <= 1'b1;
    repeat (3) @(posedge clk);
    wr(REG_CTRL, 32'h055, 1'b1);
    rdc(REG_CTRL, 32'h100, 1'b0);
    wp_in <= 1'b0;
    repeat (3) @(posedge clk);
    wr(REG_CTRL, 32'h0, 1'b0);
    // every delay code
    for (int s = 0; s < 4; s++) begin
      wr(REG_CTRL, s * 32'h41, 1'b0);
      sup <= 3'h0;
      repeat (8) @(posedge clk);
      chk({sys_reset_n_oe, rail1_good_delayed_n_oe}, 2'b10);
      sup <= 3'h7;
      wt(0, n);
      lim(n, ms[s]);
      if (s > 0) chk(rail3_good_delayed_n_oe, 1'b1);
      wt(1, n);
      lim(n, ms[s]);
    end
    wr(REG_CTRL, 32'h0, 1'b0);
    wr(REG_FAULT, 32'hF, 1'b0);
    bm.press(100);
    repeat (20) @(posedge clk);
    chk(sys_reset_n_oe, 1'b0);
    bm.press(600);
    chk({sys_reset_n_oe, rail1_good_delayed_n_oe}, 2'b10);
    chk(irq, 1'b0);
    wr(REG_INT_MASK, 32'h2, 1'b0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rdc(REG_FAULT, 32'h7, 1'b0);
    apb(1'b0, REG_INT_STAT, 32'h0);
    chk(rd[INT_MR], 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wt(1, n);
    chk(n >= MR_CYCLES + 396 - 20 && n <= MR_CYCLES + 420, 1);
    sup <= 3'h5;
    repeat (8) @(posedge clk);
    chk({sys_reset_n_oe, rail4_good_delayed_n_oe}, 2'b10);
    rdc(REG_FAULT, 32'h5, 1'b0);
    sup <= 3'h7;
    repeat (100) @(posedge clk);
    sup <= 3'h6;
    repeat (4) @(posedge clk);
    sup <= 3'h7;
    wt(0, n);
    lim(n, DLY_SEL0_MS);
    dev_sel1 <= 1'b1;
    wr(REG_TARGET, 32'h2, 1'b0);
    wr(REG_CTRL, 32'h200, 1'b0);
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({sda_oe, rd[9:8]}, 3'b101);
    wr(REG_TARGET, 32'h1, 1'b0);
    repeat (4) @(posedge clk);
    chk(sda_oe, 1'b0);
    give_verdict();
  end
endmodule
